// >>> gpc_pad_model.sv
// Model of the package pins of one port.
// Assumes the bench chooses which pins an outside source drives.
`timescale 1ns/100ps
module gpc_pad_model #(
   parameter int W = 8
) (
   // Clock
   input  wire logic         aclk,
   // Block side
   input  wire logic [W-1:0] pad_out,
   input  wire logic [W-1:0] pad_oe,
   input  wire logic [W-1:0] pad_pullup,
   // Outside source
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   // Resolved pin level
   output logic      [W-1:0] lvl
);
   logic [W-1:0] flt = '0; // Floating pins wander every cycle
   always_ff @(posedge aclk) flt <= ~flt;
   // ===========================================================
   // Resolution: block drive, then outside, then pull-up
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (pad_oe[i]) lvl[i] = pad_out[i];
         else if (ext_en[i]) lvl[i] = ext_val[i];
         else if (pad_pullup[i]) lvl[i] = 1'b1;
         else lvl[i] = flt[i]; // No fixed level to rely on
      end
   end
endmodule : gpc_pad_model

// >>> gpc_pin_mux.sv
// Per-pin output mux and pad control for one port.
// Assumes peripheral enables and analog flags come from this clock.
`timescale 1ns/100ps
module gpc_pin_mux #(
   parameter int W = 8
) (
   // Port settings
   input  wire logic [W-1:0] gp_dat,
   input  wire logic [W-1:0] gp_dir,
   input  wire logic [W-1:0] pu_en,
   input  wire logic [W-1:0] slew_en,
   // Peripheral side
   input  wire logic [W-1:0] per_en,
   input  wire logic [W-1:0] per_oe,
   input  wire logic [W-1:0] per_out,
   input  wire logic [W-1:0] analog_en,
   // Pad side
   output logic      [W-1:0] pad_out,
   output logic      [W-1:0] pad_oe,
   output logic      [W-1:0] pad_pullup,
   output logic      [W-1:0] pad_slew
);
   // ==========================================================
   // One mux per pin
   for (genvar i = 0; i < W; i++) begin : g_pin
      always_comb begin
         // Peripheral wins over the port function
         if (per_en[i]) begin
            pad_out[i] = per_out[i];
            pad_oe[i]  = per_oe[i];
         end else begin
            pad_out[i] = gp_dat[i];
            pad_oe[i]  = gp_dir[i];
         end
         // No pull-up against own drive or analog use
         pad_pullup[i] = pu_en[i] & ~pad_oe[i]
                         & ~analog_en[i];
         // Slew only matters while driving
         pad_slew[i] = slew_en[i] & pad_oe[i];
      end
   end
endmodule : gpc_pin_mux

// >>> gpc_pkg.sv
// Types shared by the pin-control block.
// Assumes gpc_regs.svh is on the include path.
`include "gpc_regs.svh"
package gpc_pkg;
   // AXI write address/data as taken by the slave
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } gpc_wreq_s;
   // Software-visible control fields
   typedef struct packed {
      logic [`GPC_PA_W-1:0] dat_a;
      logic [`GPC_PA_W-1:0] dir_a;
      logic [`GPC_PA_W-1:0] pu_a;
      logic [`GPC_PA_W-1:0] slew_a;
      logic [`GPC_PB_W-1:0] dat_b;
      logic [`GPC_PB_W-1:0] dir_b;
      logic [`GPC_PB_W-1:0] pu_b;
      logic                 bkgd_en;
   } gpc_ctrl_s;
   // Slave handshake states
   typedef enum logic [2:0] {
      GPC_IDLE = 3'b001,
      GPC_RESP = 3'b010,
      GPC_HOLD = 3'b100
   } gpc_bus_e;
endpackage : gpc_pkg

// >>> gpc_regs.svh
// Register map, field layout and reset values of the pin-control block.
// Assumes inclusion by the package, the design modules and the bench.
// Notes on behaviour
// - Two ports, fourteen pins, one out-only, one in-only
// - Enabled peripheral takes the pin over
// - Peripheral functions disabled after reset, except debug on output-only pin
// - Reset: directions input, pull-ups off
// - Output-only pin defaults to debug mode-select
// - Data and direction registers per port
// - Port A pull-up enables in bits 5:0
// - Port B pull-up enables in bits 7:0
// - Pull-up off while pin drives output
// - Pull-up off under analog control
// - Port A slew enables in bits 5:0
// - Slew enable ignored on input pins
// - Slew bits 7:6 read zero, 5:0 reset one
// - Pull-up bit 4 ignored on output-only pin
// - Slew bit 5 ignored on input-only pin
// - Port B controls independent of data/direction
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// ==========================================================
// Port geometry
`define GPC_PA_W        6
`define GPC_PB_W        8
`define GPC_PA_OUT_ONLY 4
`define GPC_PA_IN_ONLY  5

// ==========================================================
// Word indices of the registers (address bits 5:2)
`define GPC_OFS_PA_DATA   4'h0
`define GPC_OFS_PA_DIR    4'h1
`define GPC_OFS_PA_PULLUP 4'h2
`define GPC_OFS_PA_SLEW   4'h3
`define GPC_OFS_PB_DATA   4'h4
`define GPC_OFS_PB_DIR    4'h5
`define GPC_OFS_PB_PULLUP 4'h6
`define GPC_OFS_PERIPH_A  4'h7
`define GPC_OFS_PERIPH_B  4'h8
`define GPC_IDX_LSB       2
`define GPC_IDX_W         4

// ==========================================================
// Reset values
`define GPC_RST_DIR_A     6'h00
`define GPC_RST_DIR_B     8'h00
`define GPC_RST_PU_A      6'h00
`define GPC_RST_PU_B      8'h00
`define GPC_RST_SLEW_A    6'h3f
`define GPC_RST_PERIPH    1'b0
`define GPC_RST_BKGD      1'b1
`define GPC_RESP_OKAY     2'b00
`define GPC_RESP_SLVERR   2'b10

`endif

// >>> gpc_sync.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes asynchronous inputs and one clock aclk.
`timescale 1ns/100ps
module gpc_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;   // First stage, read only by second
   // ==========================================================
   // Both stages; reset to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : gpc_sync

// >>> gpc_top.sv
// Pin-control block for two general-purpose ports, AXI4-Lite slave.
// Assumes pads, peripherals and analog owners sit outside; one clock.
`timescale 1ns/100ps
`include "gpc_regs.svh"
module gpc_top
   import gpc_pkg::*;
(
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // AXI4-Lite write address
   input  wire logic [31:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Peripherals sharing port A
   input  wire logic [`GPC_PA_W-1:0] per_a_en,
   input  wire logic [`GPC_PA_W-1:0] per_a_oe,
   input  wire logic [`GPC_PA_W-1:0] per_a_out,
   input  wire logic [`GPC_PA_W-1:0] analog_a_en,
   // Peripherals sharing port B
   input  wire logic [`GPC_PB_W-1:0] per_b_en,
   input  wire logic [`GPC_PB_W-1:0] per_b_oe,
   input  wire logic [`GPC_PB_W-1:0] per_b_out,
   input  wire logic [`GPC_PB_W-1:0] analog_b_en,
   // Background debug on the output-only pin
   input  wire logic                 bkgd_out,
   input  wire logic                 bkgd_oe,
   // Port A pads
   input  wire logic [`GPC_PA_W-1:0] pad_a_in,
   output logic      [`GPC_PA_W-1:0] pad_a_out,
   output logic      [`GPC_PA_W-1:0] pad_a_oe,
   output logic      [`GPC_PA_W-1:0] pad_a_pullup,
   output logic      [`GPC_PA_W-1:0] pad_a_slew,
   // Port B pads
   input  wire logic [`GPC_PB_W-1:0] pad_b_in,
   output logic      [`GPC_PB_W-1:0] pad_b_out,
   output logic      [`GPC_PB_W-1:0] pad_b_oe,
   output logic      [`GPC_PB_W-1:0] pad_b_pullup,
   output logic      [`GPC_PB_W-1:0] pad_b_slew
);

   // ==========================================================
   // State
   typedef struct packed {
      gpc_ctrl_s   ctl;
      gpc_bus_e    wst;
      gpc_bus_e    rst;
      logic        aw_got;
      logic        w_got;
      gpc_wreq_s   wq;
      logic [1:0]  bresp;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } gpc_state_s;

   gpc_state_s             st_reg;    // Registered state
   gpc_state_s             st_next;   // Next state
   logic [`GPC_PA_W-1:0]   sync_a;    // Port A levels on aclk
   logic [`GPC_PB_W-1:0]   sync_b;    // Port B levels on aclk
   logic [`GPC_PA_W-1:0]   dir_a_eff; // Direction with fixed pins
   logic [`GPC_PA_W-1:0]   pu_a_eff;  // Pull-up with fixed pins
   logic [`GPC_PA_W-1:0]   sl_a_eff;  // Slew with fixed pins
   logic [`GPC_PA_W-1:0]   pa_en;     // Port A owner enables
   logic [`GPC_PA_W-1:0]   pa_oe;
   logic [`GPC_PA_W-1:0]   pa_o;
   logic [`GPC_PA_W-1:0]   rd_a;      // Port A data readback
   logic [`GPC_PB_W-1:0]   rd_b;      // Port B data readback
   logic [`GPC_IDX_W-1:0]  widx;
   logic [`GPC_IDX_W-1:0]  ridx;
   logic [31:0]            wmask;     // Byte enables as bits

   // ==========================================================
   // Pin input synchronisers
   gpc_sync #(.W(`GPC_PA_W)) u_sync_a (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (pad_a_in),
      .sync_out (sync_a)
   );
   gpc_sync #(.W(`GPC_PB_W)) u_sync_b (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (pad_b_in),
      .sync_out (sync_b)
   );

   // ==========================================================
   // Port A fixed-function pins
   always_comb begin
      dir_a_eff = st_reg.ctl.dir_a;
      pu_a_eff  = st_reg.ctl.pu_a;
      sl_a_eff  = st_reg.ctl.slew_a;
      pa_en     = per_a_en;
      pa_oe     = per_a_oe;
      pa_o      = per_a_out;
      // Output-only pin: direction forced out, never pulls up
      dir_a_eff[`GPC_PA_OUT_ONLY] = 1'b1;
      pu_a_eff[`GPC_PA_OUT_ONLY]  = 1'b0;
      // Input-only pin: never drives, slew meaningless
      dir_a_eff[`GPC_PA_IN_ONLY]  = 1'b0;
      sl_a_eff[`GPC_PA_IN_ONLY]   = 1'b0;
      pa_oe[`GPC_PA_IN_ONLY]      = 1'b0;
      // Debug function owns the output-only pin when enabled
      if (st_reg.ctl.bkgd_en) begin
         pa_en[`GPC_PA_OUT_ONLY] = 1'b1;
         pa_oe[`GPC_PA_OUT_ONLY] = bkgd_oe;
         pa_o[`GPC_PA_OUT_ONLY]  = bkgd_out;
      end
   end

   // ==========================================================
   // Pad muxes
   gpc_pin_mux #(.W(`GPC_PA_W)) u_mux_a (
      .gp_dat     (st_reg.ctl.dat_a),
      .gp_dir     (dir_a_eff),
      .pu_en      (pu_a_eff),
      .slew_en    (sl_a_eff),
      .per_en     (pa_en),
      .per_oe     (pa_oe),
      .per_out    (pa_o),
      .analog_en  (analog_a_en),
      .pad_out    (pad_a_out),
      .pad_oe     (pad_a_oe),
      .pad_pullup (pad_a_pullup),
      .pad_slew   (pad_a_slew)
   );
   // Port B pad settings stand apart from data/direction
   gpc_pin_mux #(.W(`GPC_PB_W)) u_mux_b (
      .gp_dat     (st_reg.ctl.dat_b),
      .gp_dir     (st_reg.ctl.dir_b),
      .pu_en      (st_reg.ctl.pu_b),
      .slew_en    ({`GPC_PB_W{1'b0}}),
      .per_en     (per_b_en),
      .per_oe     (per_b_oe),
      .per_out    (per_b_out),
      .analog_en  (analog_b_en),
      .pad_out    (pad_b_out),
      .pad_oe     (pad_b_oe),
      .pad_pullup (pad_b_pullup),
      .pad_slew   (pad_b_slew)
   );

   // ==========================================================
   // Data readback: pin level for inputs, latch for outputs
   always_comb begin
      rd_a = (dir_a_eff & st_reg.ctl.dat_a) | (~dir_a_eff & sync_a);
      rd_b = (st_reg.ctl.dir_b & st_reg.ctl.dat_b)
             | (~st_reg.ctl.dir_b & sync_b);
   end

   // ==========================================================
   // Bus handshakes; ready is high only while idle and not held
   assign s_axi_awready = (st_reg.wst == GPC_IDLE) & ~st_reg.aw_got;
   assign s_axi_wready  = (st_reg.wst == GPC_IDLE) & ~st_reg.w_got;
   assign s_axi_bvalid  = (st_reg.wst == GPC_RESP);
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_arready = (st_reg.rst == GPC_IDLE);
   assign s_axi_rvalid  = (st_reg.rst == GPC_RESP);
   assign s_axi_rdata   = st_reg.rdata;
   assign s_axi_rresp   = st_reg.rresp;

   assign widx = st_reg.wq.addr[`GPC_IDX_LSB +: `GPC_IDX_W];
   assign ridx = s_axi_araddr[`GPC_IDX_LSB +: `GPC_IDX_W];
   for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b +: 8] = {8{st_reg.wq.strb[b]}};
   end

   // ==========================================================
   // Next-state logic: register writes and reads
   always_comb begin
      logic [31:0] wv;
      wv      = '0;
      st_next = st_reg;
      // Write channel capture, either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.aw_got  = 1'b1;
         st_next.wq.addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.w_got   = 1'b1;
         st_next.wq.data = s_axi_wdata;
         st_next.wq.strb = s_axi_wstrb;
      end
      unique case (st_reg.wst)
         GPC_IDLE: begin
            if (st_reg.aw_got && st_reg.w_got) begin
               st_next.wst   = GPC_RESP;
               st_next.bresp = `GPC_RESP_OKAY;
               st_next.aw_got = 1'b0;
               st_next.w_got  = 1'b0;
               // Masked merge with the stored value
               unique case (widx)
                  `GPC_OFS_PA_DATA: begin
                     wv = (32'(st_reg.ctl.dat_a) & ~wmask)
                          | (st_reg.wq.data & wmask);
                     st_next.ctl.dat_a = wv[`GPC_PA_W-1:0];
                  end
                  `GPC_OFS_PA_DIR: begin
                     wv = (32'(st_reg.ctl.dir_a) & ~wmask)
                          | (st_reg.wq.data & wmask);
                     st_next.ctl.dir_a = wv[`GPC_PA_W-1:0];
                  end
                  `GPC_OFS_PA_PULLUP: begin
                     wv = (32'(st_reg.ctl.pu_a) & ~wmask)
                          | (st_reg.wq.data & wmask);
                     st_next.ctl.pu_a = wv[`GPC_PA_W-1:0];
                  end
                  `GPC_OFS_PA_SLEW: begin
                     wv = (32'(st_reg.ctl.slew_a) & ~wmask)
                          | (st_reg.wq.data & wmask);
                     st_next.ctl.slew_a = wv[`GPC_PA_W-1:0];
                  end
                  `GPC_OFS_PB_DATA: begin
                     wv = (32'(st_reg.ctl.dat_b) & ~wmask)
                          | (st_reg.wq.data & wmask);
                     st_next.ctl.dat_b = wv[`GPC_PB_W-1:0];
                  end
                  `GPC_OFS_PB_DIR: begin
                     wv = (32'(st_reg.ctl.dir_b) & ~wmask)
                          | (st_reg.wq.data & wmask);
                     st_next.ctl.dir_b = wv[`GPC_PB_W-1:0];
                  end
                  `GPC_OFS_PB_PULLUP: begin
                     wv = (32'(st_reg.ctl.pu_b) & ~wmask)
                          | (st_reg.wq.data & wmask);
                     st_next.ctl.pu_b = wv[`GPC_PB_W-1:0];
                  end
                  `GPC_OFS_PERIPH_A: begin
                     if (st_reg.wq.strb[0])
                        st_next.ctl.bkgd_en = st_reg.wq.data[0];
                  end
                  `GPC_OFS_PERIPH_B: ;
                  default: st_next.bresp = `GPC_RESP_SLVERR;
               endcase
            end
         end
         GPC_RESP: begin
            if (s_axi_bready) st_next.wst = GPC_IDLE;
         end
         default: st_next.wst = GPC_IDLE;
      endcase
      // Read channel; slew bits 7:6 read as zero via zero fill
      unique case (st_reg.rst)
         GPC_IDLE: begin
            if (s_axi_arvalid) begin
               st_next.rst   = GPC_RESP;
               st_next.rresp = `GPC_RESP_OKAY;
               unique case (ridx)
                  `GPC_OFS_PA_DATA:   st_next.rdata = 32'(rd_a);
                  `GPC_OFS_PA_DIR:    st_next.rdata = 32'(st_reg.ctl.dir_a);
                  `GPC_OFS_PA_PULLUP: st_next.rdata = 32'(st_reg.ctl.pu_a);
                  `GPC_OFS_PA_SLEW:
                     st_next.rdata = 32'(st_reg.ctl.slew_a);
                  `GPC_OFS_PB_DATA:   st_next.rdata = 32'(rd_b);
                  `GPC_OFS_PB_DIR:    st_next.rdata = 32'(st_reg.ctl.dir_b);
                  `GPC_OFS_PB_PULLUP: st_next.rdata = 32'(st_reg.ctl.pu_b);
                  `GPC_OFS_PERIPH_A:
                     st_next.rdata = 32'(st_reg.ctl.bkgd_en);
                  `GPC_OFS_PERIPH_B:  st_next.rdata = '0;
                  default: begin
                     st_next.rdata = '0;
                     st_next.rresp = `GPC_RESP_SLVERR;
                  end
               endcase
            end
         end
         GPC_RESP: begin
            if (s_axi_rready) st_next.rst = GPC_IDLE;
         end
         default: st_next.rst = GPC_IDLE;
      endcase
   end

   // ==========================================================
   // State register; reset values set every default
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg            <= '0;
         st_reg.wst        <= GPC_IDLE;
         st_reg.rst        <= GPC_IDLE;
         st_reg.ctl.dir_a  <= `GPC_RST_DIR_A;
         st_reg.ctl.dir_b  <= `GPC_RST_DIR_B;
         st_reg.ctl.pu_a   <= `GPC_RST_PU_A;
         st_reg.ctl.pu_b   <= `GPC_RST_PU_B;
         st_reg.ctl.slew_a <= `GPC_RST_SLEW_A;
         // Debug/mode-select owns output-only pin after reset
         st_reg.ctl.bkgd_en <= `GPC_RST_BKGD;
      end else begin
         st_reg <= st_next;
      end
   end
   // Shared peripheral enables are inputs; owners reset them
   // to off, leaving port logic in control of every pin but the output-only one.

endmodule : gpc_top

// >>> gpc_top_properties.sv
// Checker for the pin-control block, bound to its top module.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/100ps
module gpc_top_properties (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Peripheral and analog owners
   input wire logic [7:0]  per_b_en,
   input wire logic [7:0]  per_b_oe,
   input wire logic [7:0]  per_b_out,
   input wire logic [5:0]  analog_a_en,
   input wire logic [7:0]  analog_b_en,
   input wire logic        bkgd_out,
   input wire logic        bkgd_oe,
   // Pads
   input wire logic [5:0]  pad_a_out,
   input wire logic [5:0]  pad_a_oe,
   input wire logic [5:0]  pad_a_pullup,
   input wire logic [7:0]  pad_b_out,
   input wire logic [7:0]  pad_b_oe,
   input wire logic [7:0]  pad_b_pullup
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ===========================================================
   // Bus steps
   // Both halves of a write taken at one edge
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Read data held while the master stalls
   sequence s_rd_stall;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rd_hold: assert property (
      s_rd_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped while stalled");
   // ===========================================================
   // Pad rules
   a_pu_output: assert property (
      (pad_a_oe & pad_a_pullup) == 6'h00 &&
      (pad_b_oe & pad_b_pullup) == 8'h00)
      else $error("pull-up on while driving");
   a_pu_analog: assert property (
      (analog_a_en & pad_a_pullup) == 6'h00 &&
      (analog_b_en & pad_b_pullup) == 8'h00)
      else $error("pull-up on under analog control");
   a_per_owns: assert property (
      (per_b_en & (pad_b_oe ^ per_b_oe)) == 8'h00 &&
      (per_b_en & per_b_oe & (pad_b_out ^ per_b_out)) == 8'h00)
      else $error("peripheral not in control of pin");
   a_in_only: assert property (!pad_a_oe[5])
      else $error("input-only pin driven");
   a_pu_bit4: assert property (!pad_a_pullup[4])
      else $error("pull-up on output-only pin");
   a_reset_dir: assert property ($rose(aresetn) |->
      (pad_b_oe & ~per_b_en) == 8'h00 && !s_axi_bvalid)
      else $error("pin driven after reset");
   a_reset_bkgd: assert property ($rose(aresetn) |->
      pad_a_oe[4] == bkgd_oe && pad_a_out[4] == bkgd_out)
      else $error("debug function not on pin after reset");
endmodule : gpc_top_properties

bind gpc_top gpc_top_properties gpc_top_properties_i (.*);

// >>> gpc_top_tb.sv
// Self-checking bench for the pin-control block.
// Assumes the register map header and a 100 MHz clock.
`timescale 1ns/100ps
`include "gpc_regs.svh"
module gpc_top_tb;
   import gpc_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, bkgd_out, bkgd_oe;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, brsp;
   logic [5:0]  per_a_en, per_a_oe, per_a_out, analog_a_en, pad_a_in;
   logic [5:0]  pad_a_out, pad_a_oe, pad_a_pullup, pad_a_slew;
   logic [5:0]  ext_a, xen_a, da, dra, pa, sa, edir, oea;
   logic [7:0]  per_b_en, per_b_oe, per_b_out, analog_b_en, pad_b_in;
   logic [7:0]  pad_b_out, pad_b_oe, pad_b_pullup, pad_b_slew;
   logic [7:0]  ext_b, xen_b, db, drb, pb, oeb;
   int fail_count = 0, n_checks = 0, seed;
   gpc_top gpc_top_i (.*);
   gpc_pad_model #(.W(6)) pad_a_i (.aclk(aclk), .pad_out(pad_a_out),
      .pad_oe(pad_a_oe), .pad_pullup(pad_a_pullup), .ext_en(xen_a),
      .ext_val(ext_a), .lvl(pad_a_in));
   gpc_pad_model #(.W(8)) pad_b_i (.aclk(aclk), .pad_out(pad_b_out),
      .pad_oe(pad_b_oe), .pad_pullup(pad_b_pullup), .ext_en(xen_b),
      .ext_val(ext_b), .lvl(pad_b_in));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ===========================================================
   // Helpers
   function automatic logic [31:0] ofs(input logic [3:0] i);
      return {26'h0, i, 2'b00};
   endfunction : ofs
   // Pin drive: owner's enable if it holds the pin, else direction
   function automatic logic [7:0] sel(input logic [7:0] en, po, dir);
      return (en & po) | (~en & dir);
   endfunction : sel
   task automatic chk(input string n, input logic [31:0] e, s);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [31:0] a, d);
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      brsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
      // Ready sometimes low in the address cycle only; read data never stands stalled
      s_axi_rready <= 1'(($urandom() & 32'h1));
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         s_axi_rready <= 1'b1;
      end
      rdat = s_axi_rdata; rrsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task close_out;
      if (fail_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   // Watchdog sized well past forty random rounds
   initial begin
      repeat (40000) @(posedge aclk);
      fail_count++;
      close_out;
   end
   // ===========================================================
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, bkgd_out, bkgd_oe} = 4'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
      {per_a_en, per_a_oe, per_a_out, analog_a_en, ext_a, xen_a} = 36'h0;
      {per_b_en, per_b_oe, per_b_out, analog_b_en, ext_b, xen_b} = 48'h0;
      seed = $urandom(22947);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      bkgd_oe <= 1'b1;
      rd(ofs(`GPC_OFS_PA_DIR)); chk("dir_a", 32'h0, rdat);
      rd(ofs(`GPC_OFS_PB_PULLUP)); chk("pu_b", 32'h0, rdat);
      rd(ofs(`GPC_OFS_PA_SLEW)); chk("slew_a", 32'h3f, rdat);
      rd(ofs(`GPC_OFS_PERIPH_A)); chk("bkgd", 32'h1, rdat);
      chk("oe_a4", 32'h1, pad_a_oe[4]);
      chk("oe_b", 32'h0, pad_b_oe);
      wr(ofs(`GPC_OFS_PA_SLEW), 32'hff);
      rd(ofs(`GPC_OFS_PA_SLEW)); chk("slew_hi", 32'h3f, rdat);
      rd(ofs(4'hc));
      chk("unmapped", 32'h8000_0000, {rrsp, rdat[29:0]});
      wr(ofs(4'hc), 32'hffff_ffff);
      chk("bresp_err", 32'h2, brsp);
      // Debug owns pin 4 but leaves it undriven: pull-up bit 4 ignored
      wr(ofs(`GPC_OFS_PA_PULLUP), 32'h3f);
      bkgd_oe <= 1'b0;
      @(posedge aclk);
      #1;
      chk("oe_a_bkgd", 32'h0, pad_a_oe);
      chk("pu_a_bkgd", 32'h2f, pad_a_pullup);
      wr(ofs(`GPC_OFS_PERIPH_A), 32'h0);
      chk("bresp_ok", 32'h0, brsp);
      for (int k = 0; k < 40; k++) begin
         {da, dra, pa, sa} = 24'($urandom());
         {db, drb, pb} = 24'($urandom());
         if (k == 0) {dra, drb, pa, pb} = 28'hfffffff; // All out, pulls on
         wr(ofs(`GPC_OFS_PA_DATA), {26'h0, da});
         wr(ofs(`GPC_OFS_PA_DIR), {26'h0, dra});
         wr(ofs(`GPC_OFS_PA_PULLUP), {26'h0, pa});
         wr(ofs(`GPC_OFS_PA_SLEW), {26'h0, sa});
         wr(ofs(`GPC_OFS_PB_DATA), {24'h0, db});
         wr(ofs(`GPC_OFS_PB_DIR), {24'h0, drb});
         wr(ofs(`GPC_OFS_PB_PULLUP), {24'h0, pb});
         // Peripherals kept off the one-way pins of port A
         {per_a_oe, per_a_out, analog_a_en, ext_a, xen_a} <= 30'($urandom());
         per_a_en <= 6'(($urandom() & 32'h0f));
         {per_b_en, per_b_oe, per_b_out, analog_b_en} <= $urandom();
         {ext_b, xen_b, bkgd_out} <= 17'($urandom());
         @(posedge aclk);
         #1;
         edir = {2'b01, dra[3:0]};
         oeb = sel(per_b_en, per_b_oe, drb);
         oea = 6'(sel({2'h0, per_a_en}, {2'h0, per_a_oe}, {2'h0, edir}));
         chk("oe_b", oeb, pad_b_oe);
         chk("out_b", (sel(per_b_en, per_b_out, db)) & oeb,
             pad_b_out & oeb);
         chk("pu_b", pb & ~oeb & ~analog_b_en, pad_b_pullup);
         chk("oe_a", oea, pad_a_oe);
         chk("pu_a", pa & ~oea & ~analog_a_en & 6'h2f, pad_a_pullup);
         chk("slew_a", sa & oea, pad_a_slew);
         chk("slew_b", 32'h0, pad_b_slew);
         chk("out_a", 6'(sel({2'h0, per_a_en}, {2'h0, per_a_out},
             {2'h0, da})) & oea, pad_a_out & oea);
         // Owners released; outside source on every pin for readback
         {per_a_en, per_b_en, analog_a_en, analog_b_en} <= 28'h0;
         {xen_a, xen_b} <= 14'h3fff;
         repeat (4) @(posedge aclk);
         rd(ofs(`GPC_OFS_PA_DATA));
         chk("dat_a", (da & edir) | (ext_a & ~edir), rdat);
         rd(ofs(`GPC_OFS_PB_DATA));
         chk("dat_b", (db & drb) | (ext_b & ~drb), rdat);
      end
      close_out;
   end
endmodule : gpc_top_tb
